// >>> design/psb_pkg.sv
`default_nettype none
package psb_pkg;
    // ==========================================================
    // register offsets on the management serial port
    localparam logic [4:0] PSB_REG_GIG_STATUS = 5'h11;
    localparam logic [4:0] PSB_REG_BYPASS = 5'h12;
    localparam logic [4:0] PSB_REG_RX_ERR_CNT = 5'h13;

    // ==========================================================
    // gigabit status extension field positions
    localparam int PSB_GS_DESCR_LOCK = 15;
    localparam int PSB_GS_LOCK_ERR = 14;
    localparam int PSB_GS_LINK_DISC = 13;
    localparam int PSB_GS_LINK_UP = 12;
    localparam int PSB_GS_RX_ERR = 11;
    localparam int PSB_GS_TX_ERR = 10;
    localparam int PSB_GS_SSD_ERR = 9;
    localparam int PSB_GS_ESD_ERR = 8;
    localparam int PSB_GS_CEXT_ERR = 7;
    localparam int PSB_GS_LEGACY_LP = 6;
    localparam int PSB_GS_XOVER_ERR = 5;

    // ==========================================================
    // bypass control field positions and masks
    localparam int PSB_BY_TX_DIS = 15;
    localparam int PSB_BY_4B5B = 14;
    localparam int PSB_BY_SCRAM = 13;
    localparam int PSB_BY_DESCRAM = 12;
    localparam int PSB_BY_PCS_RX = 11;
    localparam int PSB_BY_PCS_TX = 10;
    localparam int PSB_BY_LINK_FAIL_HOLD = 9;
    localparam int PSB_BY_XOVER_FORCED = 7;
    localparam int PSB_BY_LEGACY_DIS = 6;
    localparam int PSB_BY_PAIR_SWAP_DIS = 5;
    localparam int PSB_BY_POL_DIS = 4;
    localparam int PSB_BY_PAR_DET = 3;
    localparam int PSB_BY_PULSE_DIS = 2;
    localparam int PSB_BY_NP_DIS = 1;
    localparam logic [15:0] PSB_BYPASS_RESET = 16'h0088;
    localparam logic [15:0] PSB_BYPASS_WR_MASK = 16'hFEFE;
    localparam logic [15:0] PSB_BYPASS_STICKY = 16'h00FA;

    // ==========================================================
    // receive error counter
    localparam int PSB_CNT_W = 8;
    localparam logic [7:0] PSB_CNT_MAX = 8'hFF;
    localparam logic [7:0] PSB_CNT_RESET = 8'h00;

    // ==========================================================
    // management frame layout
    localparam logic [5:0] PSB_PREAMBLE_LEN = 6'h20;
    localparam logic [5:0] PSB_HDR_LAST = 6'h0C;
    localparam logic [5:0] PSB_DATA_LAST = 6'h0F;
    localparam logic [5:0] PSB_DATA_LEN = 6'h10;
    localparam logic [1:0] PSB_OP_READ = 2'h2;
    localparam logic [1:0] PSB_OP_WRITE = 2'h1;

    typedef enum logic [2:0] {
        PSB_IDLE,
        PSB_HDR,
        PSB_TA,
        PSB_RDATA,
        PSB_WDATA
    } psb_mdio_state_type;
endpackage
`default_nettype wire

// >>> design/psb_mdio_slave.sv
`timescale 1ns/1ns
`default_nettype none
module psb_mdio_slave (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic mdc_pin,
    input wire logic mdio_pin_i,
    input wire logic [4:0] phy_addr_pin,
    output logic mdio_o,
    output logic mdio_oe,
    // register access
    output logic [4:0] reg_addr,
    output logic rd_stb,
    output logic wr_stb,
    output logic [15:0] wr_data,
    input wire logic [15:0] rd_data
);
    import psb_pkg::*;

    // ==========================================================
    // pin synchronisers; mdio and address are read at the second stage, the mdc edge from the second and third
    logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
    logic [4:0] addr_s1, addr_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s1 <= 1'b0;
            mdc_s2 <= 1'b0;
            mdc_s3 <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
            addr_s1 <= 5'h00;
            addr_s2 <= 5'h00;
        end else begin
            mdc_s1 <= mdc_pin;
            mdc_s2 <= mdc_s1;
            mdc_s3 <= mdc_s2;
            mdio_s1 <= mdio_pin_i;
            mdio_s2 <= mdio_s1;
            addr_s1 <= phy_addr_pin;
            addr_s2 <= addr_s1;
        end
    end

    logic rise;
    logic [12:0] hdr;
    assign rise = mdc_s2 & ~mdc_s3;
    assign hdr = {wr_data[11:0], mdio_s2};

    // ==========================================================
    // frame engine: preamble, header, turnaround, data
    psb_mdio_state_type st_q;
    logic [5:0] cnt_q;
    logic [15:0] sh_q;
    logic is_rd_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PSB_IDLE;
            cnt_q <= 6'h00;
            sh_q <= 16'h0000;
            is_rd_q <= 1'b0;
            reg_addr <= 5'h00;
            rd_stb <= 1'b0;
            wr_stb <= 1'b0;
            wr_data <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            rd_stb <= 1'b0;
            wr_stb <= 1'b0;
            if (rd_stb) begin
                sh_q <= rd_data;
            end
            if (rise) begin
                unique case (st_q)
                    PSB_IDLE: begin
                        if (mdio_s2) begin
                            if (cnt_q != PSB_PREAMBLE_LEN) begin
                                cnt_q <= cnt_q + 6'h01;
                            end
                        end else begin
                            if (cnt_q == PSB_PREAMBLE_LEN) begin
                                st_q <= PSB_HDR;
                            end
                            cnt_q <= 6'h00;
                        end
                    end
                    PSB_HDR: begin
                        // header bits gather in wr_data, which feeds hdr here; the register file reads it only on wr_stb
                        wr_data <= {wr_data[14:0], mdio_s2};
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == PSB_HDR_LAST) begin
                            cnt_q <= 6'h00;
                            reg_addr <= hdr[4:0];
                            is_rd_q <= (hdr[11:10] == PSB_OP_READ);
                            if (hdr[12] && hdr[9:5] == addr_s2
                                && (hdr[11:10] == PSB_OP_READ
                                || hdr[11:10] == PSB_OP_WRITE)) begin
                                st_q <= PSB_TA;
                                rd_stb <= (hdr[11:10] == PSB_OP_READ);
                            end else begin
                                st_q <= PSB_IDLE;
                            end
                        end
                    end
                    PSB_TA: begin
                        if (is_rd_q) begin
                            mdio_oe <= 1'b1;
                            mdio_o <= 1'b0;
                            st_q <= PSB_RDATA;
                        end else if (cnt_q == 6'h00) begin
                            cnt_q <= 6'h01;
                        end else begin
                            cnt_q <= 6'h00;
                            st_q <= PSB_WDATA;
                        end
                    end
                    PSB_RDATA: begin
                        cnt_q <= cnt_q + 6'h01;
                        mdio_o <= sh_q[15];
                        sh_q <= {sh_q[14:0], 1'b0};
                        if (cnt_q == PSB_DATA_LEN) begin
                            mdio_oe <= 1'b0;
                            mdio_o <= 1'b0;
                            cnt_q <= 6'h00;
                            st_q <= PSB_IDLE;
                        end
                    end
                    PSB_WDATA: begin
                        cnt_q <= cnt_q + 6'h01;
                        sh_q <= {sh_q[14:0], mdio_s2};
                        if (cnt_q == PSB_DATA_LAST) begin
                            wr_data <= {sh_q[14:0], mdio_s2};
                            wr_stb <= 1'b1;
                            cnt_q <= 6'h00;
                            st_q <= PSB_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/psb_regs.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// [R1] status bit 15 shows descrambler lock, bit 12 gigabit link; both reset 0
// [R2] lock error and link disconnect bits latch on events, clear after read
// [R3] receive and transmit error bits latch, clear after read, reset 0
// [R4] start, end delimiter and carrier extension error bits latch, clear on read
// [R5] bit 6 shows a non-compliant legacy link partner was seen
// [R6] bit 5 shows crossover error; bits 4 to 0 read zero
// [R7] bypass bit 15 turns the line transmitter off; resets 0
// [R8] bypass bit 14 skips 4B/5B coding; resets 0
// [R9] bits 13 to 10 skip scrambler, descrambler, PCS receive, PCS transmit
// [R10] bit 9 skips the link fail hold timer; bit 8 reads zero
// [R11] sticky bit 7, reset 1, stops auto crossover at forced 10/100
// [R12] sticky bit 6 disables legacy partner detection; resets 0
// [R13] sticky bit 5 disables pair swap correction under autonegotiation
// [R14] sticky bit 4 disables per-subchannel polarity correction
// [R15] sticky bit 3, reset 1, honours advertised ability in parallel detect
// [R16] bit 2 disables the transmit pulse shaping filter; resets 0
// [R17] sticky bit 1 stops automatic next pages, hands host control after base page
// [R18] host then sends next pages and forces the matching configuration
// [R19] 8-bit receive error counter at 100/1000, saturates at 255
// [R20] reading the counter returns the count then clears it
// [R21] soft reset keeps sticky bits only while sticky reset enable is set
module psb_regs (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SOFT_RESET,
    input wire logic STICKY_RESET_EN,
    // management serial port pins
    input wire logic MDC,
    input wire logic MDIO_I,
    output logic MDIO_O,
    output logic MDIO_OE,
    input wire logic [4:0] PHY_ADDR,
    // gigabit receive status levels
    input wire logic DESCR_LOCKED,
    input wire logic LINK_ACTIVE,
    input wire logic LEGACY_LP_SEEN,
    input wire logic XOVER_ERR_SEEN,
    // gigabit error events, one-cycle pulses
    input wire logic LOCK_ERR_EV,
    input wire logic LINK_DISC_EV,
    input wire logic RX_ERR_EV,
    input wire logic TX_ERR_EV,
    input wire logic STREAM_START_DELIMITER_ERR_EV,
    input wire logic STREAM_END_DELIMITER_ERR_EV,
    input wire logic CEXT_ERR_EV,
    // receive error counting
    input wire logic RX_ERR_CNT_EV,
    input wire logic SPEED_100_1000,
    // link state seen by the bypass controls
    input wire logic FORCED_10_100,
    input wire logic ANEG_EN,
    input wire logic BASE_PAGE_DONE,
    // datapath controls
    output logic TX_DISABLE,
    output logic BYPASS_4B5B,
    output logic BYPASS_SCRAMBLER,
    output logic BYPASS_DESCRAMBLER,
    output logic BYPASS_PCS_RX,
    output logic BYPASS_PCS_TX,
    output logic BYPASS_LINK_FAIL_HOLD_TIMER,
    output logic AUTO_XOVER_EN,
    output logic LEGACY_DETECT_EN,
    output logic PAIR_SWAP_EN,
    output logic POLARITY_CORR_EN,
    output logic PARALLEL_HONOUR_ABILITY,
    output logic PULSE_SHAPE_EN,
    output logic NEXT_PAGE_AUTO_EN,
    output logic NEXT_PAGE_HOST_CTRL
);
    import psb_pkg::*;

    function automatic logic hits(input logic [4:0] addr, input logic [4:0] off);
        hits = (addr == off);
    endfunction

    // ==========================================================
    // management serial port
    logic [4:0] reg_addr;
    logic rd_stb, wr_stb;
    logic [15:0] wr_data, rd_data;

    psb_mdio_slave u_mdio (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .mdc_pin(MDC),
        .mdio_pin_i(MDIO_I),
        .phy_addr_pin(PHY_ADDR),
        .mdio_o(MDIO_O),
        .mdio_oe(MDIO_OE),
        .reg_addr(reg_addr),
        .rd_stb(rd_stb),
        .wr_stb(wr_stb),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    logic rd_status, rd_count, wr_bypass;
    assign rd_status = rd_stb && hits(reg_addr, PSB_REG_GIG_STATUS);
    assign rd_count = rd_stb && hits(reg_addr, PSB_REG_RX_ERR_CNT);
    assign wr_bypass = wr_stb && hits(reg_addr, PSB_REG_BYPASS);

    // ==========================================================
    // gigabit status levels
    logic lock_q, link_q, legacy_q, xover_q;
    logic [15:0] byp_q;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lock_q <= 1'b0;
            link_q <= 1'b0;
            legacy_q <= 1'b0;
            xover_q <= 1'b0;
        end else begin
            // [R1] live lock and link
            lock_q <= DESCR_LOCKED;
            link_q <= LINK_ACTIVE;
            // [R5] [R12] gated legacy detect
            legacy_q <= LEGACY_LP_SEEN && !byp_q[PSB_BY_LEGACY_DIS];
            // [R6] crossover error level
            xover_q <= XOVER_ERR_SEEN;
        end
    end

    // ==========================================================
    // latched error events; an event in the read cycle survives the clear
    logic [6:0] ev, lat_q, lat_d;
    assign ev = {LOCK_ERR_EV, LINK_DISC_EV, RX_ERR_EV, TX_ERR_EV,
                 STREAM_START_DELIMITER_ERR_EV, STREAM_END_DELIMITER_ERR_EV,
                 CEXT_ERR_EV};
    // [R2] [R3] [R4] set wins over read clear
    assign lat_d = (rd_status || SOFT_RESET) ? ev : (lat_q | ev);
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lat_q <= 7'h00;
        end else begin
            lat_q <= lat_d;
        end
    end

    logic [15:0] gs_word;
    always_comb begin
        gs_word = 16'h0000;
        gs_word[PSB_GS_DESCR_LOCK] = lock_q;
        gs_word[PSB_GS_LOCK_ERR] = lat_q[6];
        gs_word[PSB_GS_LINK_DISC] = lat_q[5];
        gs_word[PSB_GS_LINK_UP] = link_q;
        gs_word[PSB_GS_RX_ERR] = lat_q[4];
        gs_word[PSB_GS_TX_ERR] = lat_q[3];
        gs_word[PSB_GS_SSD_ERR] = lat_q[2];
        gs_word[PSB_GS_ESD_ERR] = lat_q[1];
        gs_word[PSB_GS_CEXT_ERR] = lat_q[0];
        gs_word[PSB_GS_LEGACY_LP] = legacy_q;
        gs_word[PSB_GS_XOVER_ERR] = xover_q;
    end

    // ==========================================================
    // bypass control; soft reset beats a write in the same cycle
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            byp_q <= PSB_BYPASS_RESET;
        end else if (SOFT_RESET) begin
            // [R21] sticky fields survive when enabled
            if (STICKY_RESET_EN) begin
                byp_q <= (byp_q & PSB_BYPASS_STICKY)
                    | (PSB_BYPASS_RESET & ~PSB_BYPASS_STICKY);
            end else begin
                byp_q <= PSB_BYPASS_RESET;
            end
        end else if (wr_bypass) begin
            // [R10] reserved bits held at zero
            byp_q <= wr_data & PSB_BYPASS_WR_MASK;
        end
    end

    // [R7] transmitter off
    assign TX_DISABLE = byp_q[PSB_BY_TX_DIS];
    // [R8] coding bypass
    assign BYPASS_4B5B = byp_q[PSB_BY_4B5B];
    // [R9] scrambler and PCS bypasses
    assign BYPASS_SCRAMBLER = byp_q[PSB_BY_SCRAM];
    assign BYPASS_DESCRAMBLER = byp_q[PSB_BY_DESCRAM];
    assign BYPASS_PCS_RX = byp_q[PSB_BY_PCS_RX];
    assign BYPASS_PCS_TX = byp_q[PSB_BY_PCS_TX];
    // [R10] hold timer bypass
    assign BYPASS_LINK_FAIL_HOLD_TIMER = byp_q[PSB_BY_LINK_FAIL_HOLD];

    // ==========================================================
    // registered controls from bypass bits 7 to 1; crossover and pair swap also use link state
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            AUTO_XOVER_EN <= 1'b0;
            LEGACY_DETECT_EN <= 1'b0;
            PAIR_SWAP_EN <= 1'b0;
            POLARITY_CORR_EN <= 1'b0;
            PARALLEL_HONOUR_ABILITY <= 1'b0;
            PULSE_SHAPE_EN <= 1'b0;
            NEXT_PAGE_AUTO_EN <= 1'b0;
        end else begin
            // [R11] crossover held off at forced speeds
            AUTO_XOVER_EN <= !(byp_q[PSB_BY_XOVER_FORCED] && FORCED_10_100);
            // [R12] legacy detect enable
            LEGACY_DETECT_EN <= !byp_q[PSB_BY_LEGACY_DIS];
            // [R13] pair swap under autonegotiation
            PAIR_SWAP_EN <= ANEG_EN && !byp_q[PSB_BY_PAIR_SWAP_DIS];
            // [R14] polarity correction
            POLARITY_CORR_EN <= !byp_q[PSB_BY_POL_DIS];
            // [R15] parallel detect policy
            PARALLEL_HONOUR_ABILITY <= byp_q[PSB_BY_PAR_DET];
            // [R16] pulse shaping filter
            PULSE_SHAPE_EN <= !byp_q[PSB_BY_PULSE_DIS];
            // [R17] automatic next pages
            NEXT_PAGE_AUTO_EN <= !byp_q[PSB_BY_NP_DIS];
        end
    end

    // host keeps next page control until the bit is cleared or soft reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            NEXT_PAGE_HOST_CTRL <= 1'b0;
        end else if (!byp_q[PSB_BY_NP_DIS] || SOFT_RESET) begin
            NEXT_PAGE_HOST_CTRL <= 1'b0;
        end else if (BASE_PAGE_DONE) begin
            // [R17] [R18] hand over after base page
            NEXT_PAGE_HOST_CTRL <= 1'b1;
        end
    end

    // ==========================================================
    // receive error counter
    logic [7:0] cnt_q;
    logic cnt_inc;
    assign cnt_inc = RX_ERR_CNT_EV && SPEED_100_1000;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= PSB_CNT_RESET;
        end else if (SOFT_RESET) begin
            cnt_q <= PSB_CNT_RESET;
        end else if (rd_count) begin
            // [R20] clear on read, a coincident error still counts
            cnt_q <= cnt_inc ? (PSB_CNT_RESET + 8'h01) : PSB_CNT_RESET;
        end else if (cnt_inc && cnt_q != PSB_CNT_MAX) begin
            // [R19] saturating count
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // ==========================================================
    // read data; unmapped offsets read zero
    always_comb begin
        rd_data = 16'h0000;
        if (hits(reg_addr, PSB_REG_GIG_STATUS)) begin
            rd_data = gs_word;
        end else if (hits(reg_addr, PSB_REG_BYPASS)) begin
            rd_data = byp_q;
        end else if (hits(reg_addr, PSB_REG_RX_ERR_CNT)) begin
            rd_data = {8'h00, cnt_q};
        end
    end

    // ==========================================================
    // checks
    a_lock_bit_live: assert property ( // [R1]
        @(posedge REF_CLK) disable iff (!RST_N)
        $past(RST_N) && $past(DESCR_LOCKED) && $past(LINK_ACTIVE)
        |-> gs_word[15] && gs_word[12])
        else $error("lock or link bit does not follow input");

    a_event_holds_unread: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (!RST_N)
        LOCK_ERR_EV ##1 (!rd_status && !SOFT_RESET) [*3] |=> gs_word[14])
        else $error("lock error flag lost before read");

    a_read_clears_flags: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_status && ev == 7'h00 |=> gs_word[11:7] == 5'h00 && gs_word[14:13] == 2'b00)
        else $error("error flags not cleared by read");

    a_delim_flag_set: assert property ( // [R4]
        @(posedge REF_CLK) disable iff (!RST_N)
        STREAM_START_DELIMITER_ERR_EV |=> gs_word[9])
        else $error("start delimiter error not flagged");

    a_legacy_gated: assert property ( // [R12]
        @(posedge REF_CLK) disable iff (!RST_N)
        $past(byp_q[6]) |-> !gs_word[6] && !LEGACY_DETECT_EN)
        else $error("legacy detect not disabled");

    a_xover_forced_off: assert property ( // [R11]
        @(posedge REF_CLK) disable iff (!RST_N)
        byp_q[7] && FORCED_10_100 |=> !AUTO_XOVER_EN)
        else $error("auto crossover left on at forced speed");

    a_cnt_saturates: assert property ( // [R19]
        @(posedge REF_CLK) disable iff (!RST_N)
        cnt_q == 8'hFF && !rd_count && !SOFT_RESET |=> cnt_q == 8'hFF)
        else $error("receive error counter wrapped");

    a_cnt_read_clears: assert property ( // [R20]
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_count && !cnt_inc && !SOFT_RESET |=> cnt_q == 8'h00 ##1 1'b1)
        else $error("counter not cleared by read");

    a_sticky_kept: assert property ( // [R21]
        @(posedge REF_CLK) disable iff (!RST_N)
        SOFT_RESET && STICKY_RESET_EN
        |=> (byp_q & 16'h00FA) == ($past(byp_q) & 16'h00FA))
        else $error("sticky bits lost on soft reset");

    a_soft_reset_defaults: assert property ( // [R21]
        @(posedge REF_CLK) disable iff (!RST_N)
        SOFT_RESET && !STICKY_RESET_EN |=> byp_q == 16'h0088 && !TX_DISABLE)
        else $error("bypass register not back to defaults");

    a_bypass_write_lands: assert property ( // [R7]
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_bypass && !SOFT_RESET |=> byp_q == ($past(wr_data) & PSB_BYPASS_WR_MASK))
        else $error("bypass write did not land");

    a_bypass_reserved_zero: assert property ( // [R10]
        @(posedge REF_CLK) disable iff (!RST_N)
        (byp_q & ~PSB_BYPASS_WR_MASK) == 16'h0000)
        else $error("reserved bypass bit set");

    a_pair_swap_gated: assert property ( // [R13]
        @(posedge REF_CLK) disable iff (!RST_N)
        !ANEG_EN || byp_q[PSB_BY_PAIR_SWAP_DIS] |=> !PAIR_SWAP_EN)
        else $error("pair swap correction left on");

    a_polarity_off: assert property ( // [R14]
        @(posedge REF_CLK) disable iff (!RST_N)
        byp_q[PSB_BY_POL_DIS] |=> !POLARITY_CORR_EN)
        else $error("polarity correction left on");

    a_parallel_policy: assert property ( // [R15]
        @(posedge REF_CLK) disable iff (!RST_N)
        byp_q[PSB_BY_PAR_DET] |=> PARALLEL_HONOUR_ABILITY)
        else $error("parallel detect ignores ability");

    a_pulse_filter_off: assert property ( // [R16]
        @(posedge REF_CLK) disable iff (!RST_N)
        byp_q[PSB_BY_PULSE_DIS] |=> !PULSE_SHAPE_EN)
        else $error("pulse shaping filter left on");

    a_np_handover: assert property ( // [R17]
        @(posedge REF_CLK) disable iff (!RST_N)
        byp_q[PSB_BY_NP_DIS] && BASE_PAGE_DONE && !SOFT_RESET
        |=> NEXT_PAGE_HOST_CTRL && !NEXT_PAGE_AUTO_EN)
        else $error("next page control not handed to host");

    a_cnt_counts_error: assert property ( // [R19]
        @(posedge REF_CLK) disable iff (!RST_N)
        cnt_inc && !rd_count && !SOFT_RESET && cnt_q != PSB_CNT_MAX
        |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("receive error not counted");
endmodule
`default_nettype wire

// >>> dv/psb_mdio_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// management host: mdc rests low between frames
module psb_mdio_host (
    // serial port
    output logic mdc,
    output logic mdo,
    output logic mdo_en,
    input wire logic mdi
);
    initial begin
        mdc = 1'b0;
        mdo_en = 1'b0;
    end
    // host owns every frame
    // h is start, op, address, register and turnaround
    task automatic frame(input logic [15:0] h, input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, h, wd};
        for (int i = 0; i < 64; i++) begin
            // a read lets go of the line for turnaround and data
            mdo_en = (h[13:12] != 2'b10) || (i < 46);
            mdo = f[63 - i];
            #200;
            if (i > 47) begin
                rd[63 - i] = mdi;
            end
            mdc = 1'b1;
            #200;
            mdc = 1'b0;
        end
        mdo_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> dv/phy_status_bypass_error_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module phy_status_bypass_error_regs_bench;
    import psb_pkg::*;
    localparam logic [4:0] PA = 5'h05;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sticky_en = 1'b1;
    logic spd = 1'b0;
    logic forced = 1'b1;
    logic aneg = 1'b1;
    logic [3:0] lv = 4'h0;
    // soft reset, base page, count, then seven status events
    logic [9:0] p = 10'h000;
    logic mdc, h_o, h_en, d_o, d_oe, mdio;
    logic [14:0] ctl;
    logic [15:0] rv;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    // released line floats to the pull-up level
    assign mdio = h_en ? h_o : (d_oe ? d_o : 1'b1);
    psb_mdio_host u_psb_mdio_host (.mdc(mdc), .mdo(h_o), .mdo_en(h_en), .mdi(mdio));
    psb_regs u_psb_regs (
        .REF_CLK(clk), .RST_N(rst_n), .SOFT_RESET(p[9]), .STICKY_RESET_EN(sticky_en),
        .MDC(mdc), .MDIO_I(mdio), .MDIO_O(d_o), .MDIO_OE(d_oe), .PHY_ADDR(PA),
        .DESCR_LOCKED(lv[3]), .LINK_ACTIVE(lv[2]), .LEGACY_LP_SEEN(lv[1]),
        .XOVER_ERR_SEEN(lv[0]), .LOCK_ERR_EV(p[6]), .LINK_DISC_EV(p[5]), .RX_ERR_EV(p[4]),
        .TX_ERR_EV(p[3]), .STREAM_START_DELIMITER_ERR_EV(p[2]),
        .STREAM_END_DELIMITER_ERR_EV(p[1]), .CEXT_ERR_EV(p[0]), .RX_ERR_CNT_EV(p[7]),
        .SPEED_100_1000(spd), .FORCED_10_100(forced), .ANEG_EN(aneg), .BASE_PAGE_DONE(p[8]),
        .TX_DISABLE(ctl[14]), .BYPASS_4B5B(ctl[13]), .BYPASS_SCRAMBLER(ctl[12]),
        .BYPASS_DESCRAMBLER(ctl[11]), .BYPASS_PCS_RX(ctl[10]), .BYPASS_PCS_TX(ctl[9]),
        .BYPASS_LINK_FAIL_HOLD_TIMER(ctl[8]), .AUTO_XOVER_EN(ctl[7]),
        .LEGACY_DETECT_EN(ctl[6]), .PAIR_SWAP_EN(ctl[5]), .POLARITY_CORR_EN(ctl[4]),
        .PARALLEL_HONOUR_ABILITY(ctl[3]), .PULSE_SHAPE_EN(ctl[2]),
        .NEXT_PAGE_AUTO_EN(ctl[1]), .NEXT_PAGE_HOST_CTRL(ctl[0])
    );
    // ==========================================
    // access and compare tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        u_psb_mdio_host.frame({2'b01, PSB_OP_READ, PA, a, 2'b10}, 16'h0000, rv);
        chk("read data", e, rv);
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] a, input logic [15:0] d);
        u_psb_mdio_host.frame({2'b01, PSB_OP_WRITE, pa, a, 2'b10}, d, rv);
    endtask
    task automatic pls(input logic [9:0] v);
        @(negedge clk);
        p = v;
        @(negedge clk);
        p = 10'h000;
    endtask
    function automatic logic [15:0] ctl_exp(input logic [15:0] b, input logic h);
        return {1'b0, b[15:9], !(b[7] && forced), !b[6], aneg && !b[5], !b[4], b[3], !b[2],
            !b[1], h};
    endfunction
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================
    // clock, run limit and scenarios
    initial begin
        forever #5 clk = !clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        rd(PSB_REG_GIG_STATUS, 16'h0000);
        rd(PSB_REG_BYPASS, 16'h0088);
        chk("controls", ctl_exp(16'h0088, 1'b0), {1'b0, ctl});
        rd(PSB_REG_RX_ERR_CNT, 16'h0000);
        lv = 4'hF;
        pls(10'h07F);
        rd(PSB_REG_GIG_STATUS, 16'hFFE0);
        rd(PSB_REG_GIG_STATUS, 16'h9060);
        wr(PA, PSB_REG_BYPASS, 16'hFFFF);
        rd(PSB_REG_BYPASS, 16'hFEFE);
        rd(PSB_REG_GIG_STATUS, 16'h9020);
        pls(10'h100);
        chk("controls", ctl_exp(16'hFEFE, 1'b1), {1'b0, ctl});
        forced = 1'b0;
        aneg = 1'b0;
        pls(10'h000);
        chk("controls", ctl_exp(16'hFEFE, 1'b1), {1'b0, ctl});
        pls(10'h200);
        rd(PSB_REG_BYPASS, 16'h00FA);
        chk("controls", ctl_exp(16'h00FA, 1'b0), {1'b0, ctl});
        sticky_en = 1'b0;
        pls(10'h200);
        rd(PSB_REG_BYPASS, 16'h0088);
        // a frame for another address must leave the register alone
        wr(PA ^ 5'h01, PSB_REG_BYPASS, 16'hFFFF);
        rd(PSB_REG_BYPASS, 16'h0088);
        wr(PA, PSB_REG_BYPASS, 16'h0000);
        rd(PSB_REG_BYPASS, 16'h0000);
        forced = 1'b1;
        aneg = 1'b1;
        pls(10'h000);
        chk("controls", ctl_exp(16'h0000, 1'b0), {1'b0, ctl});
        spd = 1'b1;
        repeat (3) pls(10'h080);
        spd = 1'b0;
        pls(10'h080);
        rd(PSB_REG_RX_ERR_CNT, 16'h0003);
        rd(PSB_REG_RX_ERR_CNT, 16'h0000);
        spd = 1'b1;
        repeat (300) pls(10'h080);
        rd(PSB_REG_RX_ERR_CNT, 16'h00FF);
        rd(5'h14, 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire
